// ==== core/iipt_params.svh ====
/*
 Timing constants, field widths and reset values for the periodic pipe interval timer.
 Assumes inclusion by its bare name from the package and design files.
*/
`ifndef IIPT_PARAMS_SVH
`define IIPT_PARAMS_SVH
`define IIPT_EXP_W          3
`define IIPT_EXP_RESET      3'h0
`define IIPT_CNT_W          8
`define IIPT_SOF_PERIOD_NS  125000
`define IIPT_CLK_PERIOD_NS  20
`define IIPT_SOF_PREDICT    (`IIPT_SOF_PERIOD_NS / `IIPT_CLK_PERIOD_NS)
`define IIPT_SOF_SLACK      32
`define IIPT_PRED_W         16
`define IIPT_FS_PER_FRAME   8
`define IIPT_NUM_PIPES      9
`define IIPT_NOEXP_FIRST    3
`define IIPT_NOEXP_LAST     5
`endif

// ==== core/iipt_pkg.sv ====
/*
 Types for the periodic pipe interval timer.
 Assumes iipt_params.svh is on the include path.
*/
`include "iipt_params.svh"
package iipt_pkg;
    typedef enum logic [1:0] {
        IIPT_XFER_BULK = 2'h0,
        IIPT_XFER_INTR = 2'h1,
        IIPT_XFER_ISO  = 2'h2,
        IIPT_XFER_CTRL = 2'h3
    } iipt_xfer_t;

    typedef struct packed {
        logic       hostMode;
        iipt_xfer_t xferType;
        logic       dirIn;
        logic       splitSlow;
        logic       isoInFlushEnable;
        logic       doubleBufferSelect;
    } iipt_cfg_t;

    typedef struct packed {
        logic tokenIssue;
        logic zeroLengthSend;
        logic fifoFlush;
        logic flushOneSide;
        logic notReadyEvent;
        logic overrunFlag;
    } iipt_evt_t;

    typedef enum logic [2:0] {
        IIPT_IDLE = 3'b001,
        IIPT_WAIT = 3'b010,
        IIPT_RUN  = 3'b100
    } iipt_state_t;
endpackage

// ==== core/iipt_sof_tracker.sv ====
/*
 Start-of-frame tracker: passes good frame starts and, when one arrives corrupt,
 supplies an interpolated frame start one frame period after the last.
 Assumes sofGood and sofCorrupt come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "iipt_params.svh"
module iipt_sof_tracker
    import iipt_pkg::*;
#(
    parameter int PREDICT = `IIPT_SOF_PREDICT,
    parameter int SLACK   = `IIPT_SOF_SLACK
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Bus events
    input  wire logic sofGood,
    input  wire logic sofCorrupt,
    // Frame tick
    output logic      frameTick
);
    initial begin
        if (PREDICT < 2 || PREDICT + SLACK >= (1 << `IIPT_PRED_W)) begin
            $error("iipt_sof_tracker: bad PREDICT");
        end
    end

    localparam logic [`IIPT_PRED_W-1:0] PRED_LAST = `IIPT_PRED_W'(PREDICT - 1);
    localparam logic [`IIPT_PRED_W-1:0] PRED_MAX  = `IIPT_PRED_W'(PREDICT + SLACK);

    logic [`IIPT_PRED_W-1:0] sinceSof;
    logic [`IIPT_PRED_W-1:0] next_sinceSof;
    logic                    locked;
    logic                    next_locked;
    logic                    pendingLoss;
    logic                    next_pendingLoss;
    logic                    next_frameTick;

    always_comb begin
        next_sinceSof    = sinceSof;
        next_locked      = locked;
        next_pendingLoss = pendingLoss;
        next_frameTick   = 1'b0;
        if (sofGood) begin
            next_sinceSof    = '0;
            next_locked      = 1'b1;
            next_pendingLoss = 1'b0;
            next_frameTick   = 1'b1;
        end else begin
            if (sofCorrupt) begin
                next_pendingLoss = locked;
            end
            if (locked && sinceSof == PRED_LAST) begin
                // Predicted arrival: act now if the frame start was lost
                if (pendingLoss || sofCorrupt) begin
                    next_frameTick   = 1'b1; // R4
                    next_sinceSof    = '0;
                    next_pendingLoss = 1'b0;
                end else begin
                    next_sinceSof = sinceSof + 1'b1;
                end
            end else if (locked && sinceSof == PRED_MAX) begin
                // Bus gone silent: stop interpolating
                next_locked = 1'b0;
            end else if (locked) begin
                next_sinceSof = sinceSof + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sinceSof    <= '0;
            locked      <= 1'b0;
            pendingLoss <= 1'b0;
            frameTick   <= 1'b0;
        end else begin
            sinceSof    <= next_sinceSof;
            locked      <= next_locked;
            pendingLoss <= next_pendingLoss;
            frameTick   <= next_frameTick;
        end
    end
endmodule

// ==== core/iipt_interval_counter.sv ====
/*
 Interval counter for one periodic pipe: counts frame ticks and marks
 the last tick of every 2^exponent window.
 Assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "iipt_params.svh"
module iipt_interval_counter
    import iipt_pkg::*;
#(
    parameter int EXP_W = `IIPT_EXP_W,
    parameter int CNT_W = `IIPT_CNT_W
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Control
    input  wire logic             restart,
    input  wire logic             tick,
    input  wire logic [EXP_W-1:0] exponent,
    // Status
    output logic                  wrap
);
    initial begin
        if (CNT_W < (1 << EXP_W) - 1) begin
            $error("iipt_interval_counter: CNT_W too small");
        end
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] limit;
    logic             next_wrap;

    always_comb begin
        limit      = CNT_W'((1 << exponent) - 1);
        next_count = count;
        next_wrap  = 1'b0;
        if (restart) begin
            next_count = '0; // R18
        end else if (tick) begin
            if (count >= limit) begin
                next_count = '0; // R19
                next_wrap  = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= '0;
            wrap  <= 1'b0;
        end else begin
            count <= next_count;
            wrap  <= next_wrap;
        end
    end
endmodule

// ==== core/iipt_pipe_timer.sv ====
/*
 Interval timing for the periodic pipes of a USB controller: peripheral-mode
 flush of isochronous IN buffers on missing tokens when fifoHasData is low, and host-mode token spacing
 with not-ready, overrun and zero-length handling.
 Assumes bus events, FIFO state and software writes are on the controller clock;
 the selected pipe index addresses the exponent written by software.
*/
`timescale 1ns/1ps
`include "iipt_params.svh"
// Contract
// R1: Peripheral iso IN: flush when token missed (code flushes only while fifoHasData is low)
// R2: Double buffer: flush only previous side
// R3: Flush acts at following frame start
// R4: Corrupt frame start: flush at prediction
// R5: Software keeps flush off outside iso peripheral
// R6: Software changes exponent only when idle
// R7: Software checks split and busy first
// R8: Software sets NAK then auto clear
// R9: Pipes three to five have no exponent
// R10: Host: exponent writable for iso/interrupt only
// R11: Host: one token per 2^exponent frames
// R12: Split slow pipes count whole frames
// R13: Counting starts frame after response enabled
// R14: Iso host token issued despite not-ready
// R15: Iso IN: bad or no reply, not-ready (code raises not-ready only on inReplyBad in the cycle evt.tokenIssue is high)
// R16: Iso IN full at token: overrun, not-ready
// R17: Iso OUT empty: overrun, not-ready, zero-length
// R18: Reset and auto clear restart interval
// R19: One counter per pipe wrapping at 2^exponent
module iipt_pipe_timer
    import iipt_pkg::*;
#(
    parameter int NUM_PIPES = `IIPT_NUM_PIPES,
    parameter int EXP_W     = `IIPT_EXP_W,
    parameter int PREDICT   = `IIPT_SOF_PREDICT
) (
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    // Frame start events from the receiver
    input  wire logic                         sofGood,
    input  wire logic                         sofCorrupt,
    // Selected pipe configuration
    input  wire logic [3:0]                   currentPipe,
    input  wire iipt_cfg_t                    cfg,
    // Software exponent write
    input  wire logic                         exponentWrite,
    input  wire logic [EXP_W-1:0]             exponentData,
    // Per-pipe response and auto clear
    input  wire logic [NUM_PIPES-1:0]         pipeResponseBuf,
    input  wire logic [NUM_PIPES-1:0]         autoBufferClear,
    // Transaction status for the selected pipe
    input  wire logic                         inTokenSeen,
    input  wire logic                         inReplyBad,
    input  wire logic                         fifoFull,
    input  wire logic                         fifoHasData,
    // Outputs
    output iipt_evt_t                         evt,
    output logic [NUM_PIPES*EXP_W-1:0]        intervalExponent
);
    initial begin
        if (NUM_PIPES < 1 || NUM_PIPES > 15 || EXP_W < 1) begin
            $error("iipt_pipe_timer: unsupported NUM_PIPES or EXP_W");
        end
        if ((1 << EXP_W) - 1 > `IIPT_CNT_W) begin
            $error("iipt_pipe_timer: EXP_W too wide for the interval counter");
        end
        if (`IIPT_FS_PER_FRAME != 8) begin
            $error("iipt_pipe_timer: frame divider is three bits wide");
        end
    end

    logic                 frameTick;
    logic                 slowTick;
    logic [2:0]           slowDiv;
    logic [2:0]           next_slowDiv;
    logic [NUM_PIPES-1:0] wrap;
    logic [NUM_PIPES-1:0] restart;
    logic [NUM_PIPES-1:0] respPrev;
    logic [NUM_PIPES-1:0] armed;
    logic [NUM_PIPES-1:0] next_armed;
    logic [NUM_PIPES-1:0] tokenMissed;
    logic [NUM_PIPES-1:0] next_tokenMissed;
    logic [NUM_PIPES-1:0] sideToggle;
    logic [NUM_PIPES-1:0] next_sideToggle;
    logic [NUM_PIPES*EXP_W-1:0] next_intervalExponent;
    iipt_evt_t            next_evt;
    iipt_state_t          state;
    iipt_state_t          next_state;
    logic                 selValid;
    logic                 selIso;
    logic                 selPeriodic;
    logic                 selWrap;
    logic                 selArmed;
    logic                 flushNow;

    iipt_sof_tracker #(
        .PREDICT (PREDICT),
        .SLACK   (`IIPT_SOF_SLACK)
    ) sofTracker (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .sofGood    (sofGood),
        .sofCorrupt (sofCorrupt),
        .frameTick  (frameTick)
    );

    // Whole-frame tick for split slow pipes
    always_comb begin
        next_slowDiv = slowDiv;
        if (frameTick) begin
            next_slowDiv = slowDiv + 1'b1;
        end
    end
    assign slowTick = frameTick && (slowDiv == 3'(`IIPT_FS_PER_FRAME - 1));

    genvar g;
    generate
        for (g = 0; g < NUM_PIPES; g++) begin : gPipe
            logic tickSel;
            // Rising response select restarts the count for the next frame
            assign restart[g] = autoBufferClear[g] || (pipeResponseBuf[g] && !respPrev[g]);
            assign tickSel = (cfg.splitSlow && currentPipe == 4'(g + 1)) ? slowTick
                                                                           : frameTick; // R12
            iipt_interval_counter #(
                .EXP_W (EXP_W),
                .CNT_W (`IIPT_CNT_W)
            ) counter (
                .clock    (clock),
                .sys_rst  (sys_rst),
                .restart  (restart[g]), // R13
                .tick     (tickSel && armed[g]),
                .exponent (intervalExponent[g*EXP_W +: EXP_W]),
                .wrap     (wrap[g])
            );
        end
    endgenerate

    // Decode of the selected pipe
    always_comb begin
        selValid    = currentPipe >= 4'h1 && currentPipe <= 4'(NUM_PIPES);
        selIso      = cfg.xferType == IIPT_XFER_ISO;
        selPeriodic = selIso || cfg.xferType == IIPT_XFER_INTR;
        selWrap     = 1'b0;
        selArmed    = 1'b0;
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (currentPipe == 4'(i + 1)) begin
                selWrap  = wrap[i];
                selArmed = armed[i];
            end
        end
    end

    // Exponent store; pipes three to five keep zero
    always_comb begin
        next_intervalExponent = intervalExponent;
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (exponentWrite && currentPipe == 4'(i + 1)
                && !(i + 1 >= `IIPT_NOEXP_FIRST && i + 1 <= `IIPT_NOEXP_LAST) // R9
                && (!cfg.hostMode || selPeriodic)) begin // R10
                next_intervalExponent[i*EXP_W +: EXP_W] = exponentData;
            end
        end
    end

    // Arming per pipe on the first frame tick with buffer response
    always_comb begin
        next_armed = armed;
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (!pipeResponseBuf[i] || autoBufferClear[i]) begin
                next_armed[i] = 1'b0;
            end else if (frameTick) begin
                next_armed[i] = 1'b1; // R13
            end
        end
    end

    // Missed-token tracking and buffer side per pipe
    always_comb begin
        next_tokenMissed = tokenMissed;
        next_sideToggle  = sideToggle;
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (currentPipe == 4'(i + 1)) begin
                if (inTokenSeen && !inReplyBad) begin
                    next_tokenMissed[i] = 1'b0;
                end
                if (selWrap) begin
                    // New window: assume missed until a token shows up
                    next_tokenMissed[i] = !(inTokenSeen && !inReplyBad);
                    if (flushNow && cfg.doubleBufferSelect) begin
                        next_sideToggle[i] = !sideToggle[i]; // R2
                    end
                end
            end
        end
    end

    // Peripheral flush at the window's closing frame start
    always_comb begin
        flushNow = 1'b0;
        for (int i = 0; i < NUM_PIPES; i++) begin
            if (currentPipe == 4'(i + 1)) begin
                flushNow = !cfg.hostMode && selIso && cfg.dirIn && cfg.isoInFlushEnable
                           && selWrap && tokenMissed[i] && !fifoHasData; // R1 R3
            end
        end
    end

    // Host token sequencer
    always_comb begin
        next_state = state;
        next_evt   = '0;
        case (state)
            IIPT_IDLE: begin
                if (cfg.hostMode && selValid && selPeriodic && selArmed) begin
                    next_state = IIPT_RUN;
                end
            end
            IIPT_RUN: begin
                if (!(cfg.hostMode && selArmed)) begin
                    next_state = IIPT_IDLE;
                end else if (selWrap) begin
                    next_evt.tokenIssue = 1'b1; // R11 R14
                    if (selIso && cfg.dirIn && fifoFull) begin
                        next_evt.overrunFlag   = 1'b1; // R16
                        next_evt.notReadyEvent = 1'b1;
                    end
                    if (selIso && !cfg.dirIn && !fifoHasData) begin
                        next_evt.overrunFlag    = 1'b1; // R17
                        next_evt.notReadyEvent  = 1'b1;
                        next_evt.zeroLengthSend = 1'b1;
                    end
                    next_state = IIPT_WAIT;
                end
            end
            IIPT_WAIT: begin
                if (inReplyBad && selIso && cfg.dirIn) begin
                    next_evt.notReadyEvent = 1'b1; // R15
                end
                next_state = IIPT_RUN;
            end
            default: begin
                next_state = IIPT_IDLE;
            end
        endcase
        if (flushNow) begin
            next_evt.fifoFlush    = 1'b1; // R1
            next_evt.flushOneSide = cfg.doubleBufferSelect; // R2
        end
    end

    // Frame divider for split slow pipes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slowDiv <= 3'h0;
        end else begin
            slowDiv <= next_slowDiv;
        end
    end

    // Response edge detector
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            respPrev <= '0;
        end else begin
            respPrev <= pipeResponseBuf;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            armed <= '0;
        end else begin
            armed <= next_armed;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tokenMissed <= '0;
            sideToggle  <= '0;
        end else begin
            tokenMissed <= next_tokenMissed;
            sideToggle  <= next_sideToggle;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intervalExponent <= '0; // R18
        end else begin
            intervalExponent <= next_intervalExponent;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= IIPT_IDLE;
            evt   <= '0;
        end else begin
            state <= next_state;
            evt   <= next_evt;
        end
    end
endmodule

// ==== test/iipt_pipe_timer_asserts.sv ====
/*
 Port checker for the periodic pipe interval timer.
 Assumes it is bound to iipt_pipe_timer; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module iipt_pipe_timer_chk
    import iipt_pkg::*;
#(
    parameter int NUM_PIPES = 9,
    parameter int EXP_W     = 3,
    parameter int PREDICT   = 20
) (
    // Clock and reset
    input wire logic                       clock,
    input wire logic                       sys_rst,
    // Observed inputs
    input wire logic [3:0]                 currentPipe,
    input wire iipt_cfg_t                  cfg,
    input wire logic                       exponentWrite,
    input wire logic [EXP_W-1:0]           exponentData,
    // Observed outputs
    input wire iipt_evt_t                  evt,
    input wire logic [NUM_PIPES*EXP_W-1:0] intervalExponent
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    chk_reset_clear: assert property (
        $fell(sys_rst) |-> evt == '0 && intervalExponent == '0)
        else $error("outputs not clear after reset");
    chk_no_exp_pipes: assert property (
        intervalExponent[5*EXP_W-1:2*EXP_W] == '0)
        else $error("exponent present on pipes three to five");
    chk_exp_refused: assert property (
        exponentWrite && cfg.hostMode && (cfg.xferType inside {IIPT_XFER_BULK, IIPT_XFER_CTRL})
        |=> $stable(intervalExponent))
        else $error("exponent written for non periodic type");
    chk_exp_taken: assert property (
        exponentWrite && cfg.hostMode && currentPipe == 4'h1
        && (cfg.xferType inside {IIPT_XFER_ISO, IIPT_XFER_INTR})
        |=> intervalExponent[EXP_W-1:0] == $past(exponentData))
        else $error("exponent write lost");
    chk_token_host: assert property (
        evt.tokenIssue |-> $past(cfg.hostMode)
        && ($past(cfg.xferType) inside {IIPT_XFER_ISO, IIPT_XFER_INTR}))
        else $error("token outside host periodic pipe");
    chk_zero_len: assert property (
        evt.zeroLengthSend |-> evt.tokenIssue && evt.overrunFlag && evt.notReadyEvent
        && !$past(cfg.dirIn))
        else $error("zero length send without overrun token");
    chk_overrun_event: assert property (
        evt.overrunFlag |-> evt.tokenIssue && evt.notReadyEvent)
        else $error("overrun without token and not ready");
    chk_flush_mode: assert property (
        evt.fifoFlush |-> !$past(cfg.hostMode) && $past(cfg.xferType) == IIPT_XFER_ISO
        && $past(cfg.dirIn) && $past(cfg.isoInFlushEnable))
        else $error("flush outside peripheral iso in");
    chk_one_side: assert property (
        evt.flushOneSide |-> evt.fifoFlush && $past(cfg.doubleBufferSelect))
        else $error("one side flush without double buffer");
    chk_side_full: assert property (
        evt.fifoFlush && $past(cfg.doubleBufferSelect) |-> evt.flushOneSide)
        else $error("double buffer flush cleared both sides");
endmodule

bind iipt_pipe_timer iipt_pipe_timer_chk #(
    .NUM_PIPES(NUM_PIPES),
    .EXP_W    (EXP_W),
    .PREDICT  (PREDICT)
) u_iipt_pipe_timer_chk (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .currentPipe     (currentPipe),
    .cfg             (cfg),
    .exponentWrite   (exponentWrite),
    .exponentData    (exponentData),
    .evt             (evt),
    .intervalExponent(intervalExponent)
);

// ==== test/iipt_bus_partner.sv ====
/*
 Bus partner model: frame starts once per frame, one of them spoiled on request.
 Assumes the request pulse never lands on the last cycle of a frame.
*/
`timescale 1ns/1ps
module iipt_bus_partner #(
    parameter int FRAME = 20
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Test control
    input  wire logic corruptOne,
    // Frame starts
    output logic      sofGood,
    output logic      sofCorrupt
);
    int   phase;
    logic spoil;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase      <= 0;
            spoil      <= 1'b0;
            sofGood    <= 1'b0;
            sofCorrupt <= 1'b0;
        end else begin
            phase      <= (phase == FRAME - 1) ? 0 : phase + 1;
            sofGood    <= (phase == FRAME - 1) && !spoil;
            sofCorrupt <= (phase == FRAME - 1) && spoil;
            if (corruptOne) begin
                spoil <= 1'b1;
            end else if (phase == FRAME - 1) begin
                spoil <= 1'b0;
            end
        end
    end
endmodule

// ==== test/test_iipt_pipe_timer.sv ====
/*
 Testbench for the periodic pipe interval timer.
 Assumes a shortened frame prediction matching the partner frame length.
*/
`timescale 1ns/1ps
module test_iipt_pipe_timer;
    import iipt_pkg::*;
    localparam int FRAME = 20;
    logic            clock, sys_rst, sofGood, sofCorrupt, corruptOne;
    logic [3:0]      currentPipe;
    iipt_cfg_t       cfg;
    logic            exponentWrite, inTokenSeen, inReplyBad, fifoFull, fifoHasData;
    logic [2:0]      exponentData;
    logic [8:0]      pipeResponseBuf, autoBufferClear;
    iipt_evt_t       evt;
    logic [26:0]     intervalExponent;
    int              errors, samples_checked, cnt[6], v;
    bit              replyBad;

    iipt_bus_partner #(.FRAME(FRAME)) u_iipt_bus_partner (.clock(clock), .sys_rst(sys_rst),
        .corruptOne(corruptOne), .sofGood(sofGood), .sofCorrupt(sofCorrupt));
    iipt_pipe_timer #(.PREDICT(FRAME)) u_iipt_pipe_timer (.clock(clock), .sys_rst(sys_rst),
        .sofGood(sofGood), .sofCorrupt(sofCorrupt), .currentPipe(currentPipe), .cfg(cfg),
        .exponentWrite(exponentWrite), .exponentData(exponentData),
        .pipeResponseBuf(pipeResponseBuf), .autoBufferClear(autoBufferClear),
        .inTokenSeen(inTokenSeen), .inReplyBad(inReplyBad), .fifoFull(fifoFull),
        .fifoHasData(fifoHasData), .evt(evt), .intervalExponent(intervalExponent));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("MISMATCH t=%0t got=%0h want=%0h", $time, got, want);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic setc(input bit h, input int x, input bit d, input bit f, input bit b);
        @(negedge clock);
        cfg = '{h, iipt_xfer_t'(x[1:0]), d, 1'b0, f, b};
    endtask

    task automatic wrexp(input logic [3:0] p, input logic [2:0] e);
        @(negedge clock);
        currentPipe = p;
        exponentData = e;
        exponentWrite = 1'b1;
        @(negedge clock);
        exponentWrite = 1'b0;
        currentPipe = 4'h1;
    endtask

    // Software order: NAK, auto clear, new exponent, respond again
    task automatic rearm(input logic [2:0] e);
        @(negedge clock);
        pipeResponseBuf[0] = 1'b0;
        @(negedge clock);
        autoBufferClear[0] = 1'b1;
        @(negedge clock);
        autoBufferClear[0] = 1'b0;
        wrexp(4'h1, e);
        pipeResponseBuf[0] = 1'b1;
    endtask

    // Syncs on a frame start, then counts event bits over n*FRAME-10 cycles
    task automatic run(input int n, input bit answer, input bit spoil);
        int k;
        k = 0;
        while (sofGood !== 1'b1 && k < 100) begin
            @(negedge clock);
            k++;
        end
        foreach (cnt[i]) cnt[i] = 0;
        for (k = 0; k < n * FRAME - 10; k++) begin
            @(negedge clock);
            corruptOne = spoil && k == 0;
            inTokenSeen = answer && k % FRAME == 10;
            inReplyBad = replyBad && evt.tokenIssue === 1'b1;
            for (int i = 0; i < 6; i++) cnt[i] += (evt[5-i] === 1'b1);
        end
        corruptOne = 1'b0;
        inTokenSeen = 1'b0;
        inReplyBad = 1'b0;
    endtask

    initial begin
        repeat (10000) @(posedge clock);
        errors++;
        tally_and_finish;
    end

    initial begin
        sys_rst = 1'b1;
        {corruptOne, exponentWrite, inTokenSeen, inReplyBad, fifoFull, fifoHasData} = '0;
        currentPipe = 4'h1;
        cfg = '0;
        exponentData = 3'h0;
        pipeResponseBuf = '0;
        autoBufferClear = '0;
        replyBad = 1'b0;
        repeat (16) @(negedge clock);
        check(evt, 0);
        check(intervalExponent, 0);
        sys_rst = 1'b0;
        setc(1, 2, 0, 0, 0);
        wrexp(4'h1, 3'h5);
        check(intervalExponent[2:0], 5);
        wrexp(4'h4, 3'h7);
        check(intervalExponent[11:9], 0);
        v = 0;
        for (int t = 0; t < 4; t++) begin
            setc(1, t, 0, 0, 0);
            wrexp(4'h2, 3'(t + 4));
            if (t == 1 || t == 2) v = t + 4;
            check(intervalExponent[5:3], v);
        end
        $display("test exponent writes done");
        setc(1, 2, 0, 0, 0);
        rearm(3'h0);
        run(6, 0, 0);
        for (int i = 0; i < 6; i++) check(cnt[i], (i == 2 || i == 3) ? 0 : 5);
        fifoHasData = 1'b1;
        run(4, 0, 0);
        check(cnt[0], 4);
        check(cnt[1] + cnt[5], 0);
        $display("test host iso out done");
        setc(1, 2, 1, 0, 0);
        fifoFull = 1'b1;
        rearm(3'h1);
        run(9, 0, 0);
        check(cnt[0], 4);
        check(cnt[5] + cnt[4], 8);
        fifoFull = 1'b0;
        replyBad = 1'b1;
        run(9, 0, 0);
        check(cnt[4], 4);
        check(cnt[5], 0);
        replyBad = 1'b0;
        rearm(3'h2);
        run(5, 0, 0);
        check(cnt[0], 1);
        $display("test host iso in done");
        rearm(3'h0);
        cfg.splitSlow = 1'b1;
        run(17, 0, 0);
        check(cnt[0], 2);
        $display("test split frames done");
        setc(0, 2, 1, 1, 1);
        fifoHasData = 1'b0;
        rearm(3'h0);
        run(6, 1, 0);
        check(cnt[2], 0);
        run(6, 0, 0);
        v = cnt[2];
        check(v, 6);
        check(cnt[3], v);
        run(6, 0, 1);
        check(cnt[2], v);
        setc(0, 2, 1, 1, 0);
        run(6, 0, 0);
        check(cnt[2], v);
        check(cnt[3], 0);
        $display("test peripheral flush done");
        tally_and_finish;
    end
endmodule
